// file: verilog/ttr_regs.sv
// Threshold, temperature and identification register bank with trip status.
`timescale 1ns/1ns

// Function
// - Alarm lower threshold at 03h, same format, resets to 0000h.
// - Critical threshold at 04h, same format, -256 to +255.75 degC.
// - Temperature at 05h read only, bits 12:1 at 0.125 degC, bit 0 zero.
// - Bit 12 is sign, bit 11 weighs 128 degC, halving downward.
// - Trip bits depend only on comparisons and hysteresis select, not on any other configuration.
// - Inside window when both above and below bits are zero.
// - Below bit sets under lower minus hysteresis, clears at or above lower.
// - Above bit sets over upper, clears at or below upper minus hysteresis.
// - Critical bit sets at or above critical, clears below critical minus hysteresis.
// - Read-only maker code register at 06h.
// - Read-only register at 07h holds device code and revision.
// - Hysteresis select: 00 none, 01 1.5, 10 3, 11 6 degC.
// - Hysteresis applies to window and critical comparisons alike.
// - Alarm lock blocks writes to both window thresholds until power-on reset.
// - Critical lock blocks writes to the critical threshold until power-on reset.
module ttr_regs #(
  parameter logic [15:0] MAKER_ID = 16'h0A5A,  // Arbitrary value.
  parameter logic [7:0]  PART_ID  = 8'h3C,     // Arbitrary value.
  parameter logic [7:0]  REV_ID   = 8'h01      // Arbitrary value.
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_ptr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        conv_valid,
  input  wire logic [11:0] conv_temp,
  input  wire logic [1:0]  hyst_sel,
  input  wire logic        alarm_lock,
  input  wire logic        crit_lock,
  output logic             trip_critical,
  output logic             trip_above,
  output logic             trip_below,
  output logic             in_window
);
  import ttr_pkg::*;

  logic [15:0]             upper_reg;
  logic [15:0]             lower_reg;
  logic [15:0]             crit_reg;
  logic [12:0]             temp_reg;
  logic [15:0]             temp_word;
  logic [15:0]             rdata_next;
  logic [15:0]             wr_masked;
  logic signed [CMP_W-1:0] hyst_val;
  logic signed [CMP_W-1:0] new_temp;
  logic signed [CMP_W-1:0] upper_cmp;
  logic signed [CMP_W-1:0] lower_cmp;
  logic signed [CMP_W-1:0] crit_cmp;

  // ---------------------------------------------------------------------------
  // Threshold writes
  // ---------------------------------------------------------------------------
  // Only bits 12:2 survive a write, so reserved bits can never read back as one.
  always_comb begin
    wr_masked                  = 16'h0000;
    wr_masked[THR_MSB:THR_LSB] = reg_wdata[THR_MSB:THR_LSB];
  end

  // The window pair shares one lock; the lock itself lives in configuration.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_reg <= THR_RESET;
      lower_reg <= THR_RESET;
    end else if (reg_wr && !alarm_lock) begin
      if (reg_ptr == PTR_ALARM_UPPER) begin
        upper_reg <= wr_masked;
      end
      if (reg_ptr == PTR_ALARM_LOWER) begin
        lower_reg <= wr_masked;
      end
    end
  end

  // Critical threshold under its own lock.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      crit_reg <= THR_RESET;
    end else if (reg_wr && !crit_lock && reg_ptr == PTR_CRITICAL) begin
      crit_reg <= wr_masked;
    end
  end

  // ---------------------------------------------------------------------------
  // Temperature capture
  // ---------------------------------------------------------------------------
  // Host writes never reach here; only the converter updates the value.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_reg <= TEMP_RESET[THR_MSB:0];
    end else if (conv_valid) begin
      temp_reg <= {conv_temp, 1'b0};
    end
  end

  // ---------------------------------------------------------------------------
  // Comparison operands
  // ---------------------------------------------------------------------------
  // Bits 12:0 read as one signed number in 1/16 degC, so both steps share a scale.
  assign new_temp  = {conv_temp[11], conv_temp, 1'b0};
  assign upper_cmp = {upper_reg[THR_MSB], upper_reg[THR_MSB:0]};
  assign lower_cmp = {lower_reg[THR_MSB], lower_reg[THR_MSB:0]};
  assign crit_cmp  = {crit_reg[THR_MSB], crit_reg[THR_MSB:0]};

  // One hysteresis amount feeds all three comparators.
  always_comb begin
    unique case (hyst_sel)
      HYST_SEL_OFF: hyst_val = HYST_OFF;
      HYST_SEL_1P5: hyst_val = HYST_1P5;
      HYST_SEL_3:   hyst_val = HYST_3;
      HYST_SEL_6:   hyst_val = HYST_6;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Trip comparators
  // ---------------------------------------------------------------------------
  // They see only temperatures, thresholds and hysteresis, never event or output settings.
  ttr_trip_cmp #(.HIGH_SIDE(1'b1), .INCLUSIVE(1'b1)) u_crit (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .eval    (conv_valid),
    .temp    (new_temp),
    .thr     (crit_cmp),
    .hyst    (hyst_val),
    .trip    (trip_critical)
  );

  ttr_trip_cmp #(.HIGH_SIDE(1'b1), .INCLUSIVE(1'b0)) u_above (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .eval    (conv_valid),
    .temp    (new_temp),
    .thr     (upper_cmp),
    .hyst    (hyst_val),
    .trip    (trip_above)
  );

  ttr_trip_cmp #(.HIGH_SIDE(1'b0), .INCLUSIVE(1'b0)) u_below (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .eval    (conv_valid),
    .temp    (new_temp),
    .thr     (lower_cmp),
    .hyst    (hyst_val),
    .trip    (trip_below)
  );

  assign in_window = !trip_above && !trip_below;

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  assign temp_word = {trip_critical, trip_above, trip_below, temp_reg};

  // Unknown pointers read zero; a read has no side effect on any state.
  always_comb begin
    unique case (reg_ptr)
      PTR_ALARM_UPPER: rdata_next = upper_reg;
      PTR_ALARM_LOWER: rdata_next = lower_reg;
      PTR_CRITICAL:    rdata_next = crit_reg;
      PTR_TEMP:        rdata_next = temp_word;
      PTR_MAKER_ID:    rdata_next = MAKER_ID;
      PTR_PART_REV:    rdata_next = {PART_ID, REV_ID};
      default:         rdata_next = 16'h0000;
    endcase
  end

  // Read data is registered and holds until the next read strobe.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  upper_write_a: assert property (
    reg_wr && !alarm_lock && reg_ptr == PTR_ALARM_UPPER
    |=> upper_reg == {3'h0, $past(reg_wdata[12:2]), 2'h0})
    else $error("Upper threshold did not take the masked write.");
  window_lock_a: assert property (
    alarm_lock && reg_wr && (reg_ptr == PTR_ALARM_LOWER || reg_ptr == PTR_ALARM_UPPER)
    |=> $stable(lower_reg) && $stable(upper_reg))
    else $error("Locked window threshold changed.");
  crit_lock_a: assert property (
    crit_lock |=> $stable(crit_reg))
    else $error("Locked critical threshold changed.");
  crit_write_a: assert property (
    reg_wr && !crit_lock && reg_ptr == PTR_CRITICAL
    |=> crit_reg[12:2] == $past(reg_wdata[12:2]) && crit_reg[15:13] == 3'h0)
    else $error("Critical threshold did not take the write.");
  thr_pad_a: assert property (
    {upper_reg[15:13], upper_reg[1:0], lower_reg[15:13], lower_reg[1:0],
     crit_reg[15:13], crit_reg[1:0]} == 15'h0000)
    else $error("Unused threshold bit is set.");
  temp_store_a: assert property (
    conv_valid |=> temp_reg[12:1] == $past(conv_temp) && !temp_reg[0])
    else $error("Conversion result not stored.");
  temp_hold_a: assert property (
    !conv_valid |=> $stable(temp_word))
    else $error("Temperature word moved without a conversion.");
  read_temp_a: assert property (
    reg_rd && reg_ptr == PTR_TEMP |=> reg_rdata == $past(temp_word))
    else $error("Temperature read returned wrong data.");
  read_id_a: assert property (
    reg_rd && reg_ptr == PTR_PART_REV |=> reg_rdata == {PART_ID, REV_ID})
    else $error("Part and revision read returned wrong data.");
  read_maker_a: assert property (
    reg_rd && reg_ptr == PTR_MAKER_ID |=> reg_rdata == MAKER_ID)
    else $error("Maker code read returned wrong data.");
  window_flag_a: assert property (
    in_window |-> !temp_word[BIT_ABOVE] && !temp_word[BIT_BELOW])
    else $error("Window flag disagrees with status bits.");

endmodule : ttr_regs

// file: pkg/ttr_pkg.sv
// Package with pointers, field layouts, reset values and hysteresis steps of the threshold bank.
package ttr_pkg;

  // ---------------------------------------------------------------------------
  // Register pointers
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PTR_ALARM_UPPER = 8'h02;
  localparam logic [7:0] PTR_ALARM_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRITICAL    = 8'h04;
  localparam logic [7:0] PTR_TEMP        = 8'h05;
  localparam logic [7:0] PTR_MAKER_ID    = 8'h06;
  localparam logic [7:0] PTR_PART_REV    = 8'h07;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int THR_MSB       = 12;  // Sign bit of thresholds and temperature.
  localparam int THR_LSB       = 2;   // 0.25 degC step of the thresholds.
  localparam int TEMP_LSB      = 1;   // 0.125 degC step of the temperature.
  localparam int BIT_CRIT      = 15;
  localparam int BIT_ABOVE     = 14;
  localparam int BIT_BELOW     = 13;
  localparam int CMP_W         = 14;  // Compare width, one guard bit over 13.

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] THR_RESET  = 16'h0000;
  localparam logic [15:0] TEMP_RESET = 16'h0000;

  // ---------------------------------------------------------------------------
  // Hysteresis amounts in units of bit 0 (1/16 degC)
  // ---------------------------------------------------------------------------
  localparam logic [1:0]       HYST_SEL_OFF = 2'h0;
  localparam logic [1:0]       HYST_SEL_1P5 = 2'h1;
  localparam logic [1:0]       HYST_SEL_3   = 2'h2;
  localparam logic [1:0]       HYST_SEL_6   = 2'h3;
  localparam logic [CMP_W-1:0] HYST_OFF     = 14'h0000;
  localparam logic [CMP_W-1:0] HYST_1P5     = 14'h0018;
  localparam logic [CMP_W-1:0] HYST_3       = 14'h0030;
  localparam logic [CMP_W-1:0] HYST_6       = 14'h0060;

endpackage : ttr_pkg

// file: verilog/ttr_trip_cmp.sv
// One trip comparator with hysteresis, evaluated on each new conversion.
`timescale 1ns/1ns
module ttr_trip_cmp #(
  parameter bit HIGH_SIDE = 1'b1,  // Trips when the temperature rises.
  parameter bit INCLUSIVE = 1'b0   // High side: trip on equality too.
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic                          eval,
  input  wire logic signed [ttr_pkg::CMP_W-1:0] temp,
  input  wire logic signed [ttr_pkg::CMP_W-1:0] thr,
  input  wire logic signed [ttr_pkg::CMP_W-1:0] hyst,
  output logic                               trip
);
  import ttr_pkg::*;

  logic signed [CMP_W-1:0] thr_low;
  logic                    set_cond;
  logic                    clr_cond;

  // ---------------------------------------------------------------------------
  // Set and clear conditions
  // ---------------------------------------------------------------------------
  // The guard bit keeps threshold minus 6 degC from wrapping at -256 degC.
  assign thr_low = thr - hyst;

  // Low side sets below the lowered bound and clears at the bound itself.
  always_comb begin
    if (HIGH_SIDE) begin
      set_cond = INCLUSIVE ? (temp >= thr) : (temp > thr);
      clr_cond = INCLUSIVE ? (temp < thr_low) : (temp <= thr_low);
    end else begin
      set_cond = temp < thr_low;
      clr_cond = temp >= thr;
    end
  end

  // Between the two conditions the flag holds, which gives the hysteresis band.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip <= 1'b0;
    end else if (eval) begin
      if (set_cond) begin
        trip <= 1'b1;
      end else if (clr_cond) begin
        trip <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  trip_set_a: assert property (eval && set_cond |=> trip)
    else $error("Trip flag did not set on a tripping conversion.");
  trip_clear_a: assert property (eval && clr_cond && !set_cond |=> !trip)
    else $error("Trip flag did not clear on a releasing conversion.");
  trip_hold_a: assert property (!eval |=> $stable(trip))
    else $error("Trip flag moved without a conversion.");
  band_hold_a: assert property (eval && !set_cond && !clr_cond |=> trip == $past(trip))
    else $error("Trip flag moved inside the hysteresis band.");

endmodule : ttr_trip_cmp

// file: verif/ttr_host.sv
// Host register master that drives the pointer port of the threshold bank.
`timescale 1ns/1ns
module ttr_host (
  input  wire logic        ref_clk,
  output logic      [7:0]  reg_ptr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata
);
  // The bus is idle from time zero.
  initial begin
    reg_ptr   = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  // One write strobe; the released lines then show the inverse, so stale data never looks valid.
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(posedge ref_clk);
    reg_ptr   <= p;
    reg_wr    <= 1'b1;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_ptr   <= ~p;
    reg_wdata <= ~d;
  endtask : wr

  // One read strobe; data is taken an edge late, which is safe because it stands until the next read.
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    @(posedge ref_clk);
    reg_ptr <= p;
    reg_rd  <= 1'b1;
    @(posedge ref_clk);
    reg_rd  <= 1'b0;
    reg_ptr <= ~p;
    @(posedge ref_clk);
    #1 d = reg_rdata;
  endtask : rd
endmodule : ttr_host

// file: verif/tb_ttr_regs.sv
// Self-checking bench for the threshold bank with a host model and a trip reference model.
`timescale 1ns/1ns
module tb_ttr_regs;
  import ttr_pkg::*;
  localparam logic [15:0] MAKER_ID = 16'h0A5A;  // Arbitrary value.
  localparam logic [7:0]  PART_ID  = 8'h3C;     // Arbitrary value.
  localparam logic [7:0]  REV_ID   = 8'h01;     // Arbitrary value.
  logic        ref_clk, rst_n, reg_wr, reg_rd, conv_valid, alarm_lock, crit_lock;
  logic        trip_critical, trip_above, trip_below, in_window, m_crit, m_above, m_below;
  logic [7:0]  reg_ptr;
  logic [15:0] reg_wdata, reg_rdata, rd_val, m_up, m_lo, m_cr, m_temp;
  logic [11:0] conv_temp, base;
  logic [1:0]  hyst_sel;
  int          error_cnt, tests_run, seed, i, k;

  // Clock of 4 ns period.
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  ttr_regs #(.MAKER_ID(MAKER_ID), .PART_ID(PART_ID), .REV_ID(REV_ID)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_valid(conv_valid),
    .conv_temp(conv_temp), .hyst_sel(hyst_sel), .alarm_lock(alarm_lock), .crit_lock(crit_lock),
    .trip_critical(trip_critical), .trip_above(trip_above), .trip_below(trip_below),
    .in_window(in_window));

  ttr_host host (.ref_clk(ref_clk), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // ---------------------------------------------------------------------------
  // Compare and reference helpers
  // ---------------------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  // Value of bits 12:0 in 1/16 degC units, sign in bit 12.
  function automatic int sx(input logic [15:0] v);
    return int'($signed(v[12:0]));
  endfunction : sx

  // Hysteresis of 1.5, 3 and 6 degC in 1/16 degC units.
  function automatic int hyst_amt(input logic [1:0] s);
    return (s == 2'h0) ? 0 : (s == 2'h1) ? 24 : (s == 2'h2) ? 48 : 96;
  endfunction : hyst_amt

  function automatic logic [15:0] exp_reg(input logic [7:0] p);
    case (p)
      PTR_ALARM_UPPER: return m_up;
      PTR_ALARM_LOWER: return m_lo;
      PTR_CRITICAL:    return m_cr;
      PTR_TEMP:        return {m_crit, m_above, m_below, m_temp[12:0]};
      PTR_MAKER_ID:    return MAKER_ID;
      PTR_PART_REV:    return {PART_ID, REV_ID};
      default:         return 16'h0000;
    endcase
  endfunction : exp_reg

  // The model updates after the strobe, when the lock levels sampled by the bank are settled.
  task automatic wr_chk(input logic [7:0] p, input logic [15:0] d);
    host.wr(p, d);
    if (p == PTR_ALARM_UPPER && !alarm_lock) m_up = d & 16'h1FFC;
    if (p == PTR_ALARM_LOWER && !alarm_lock) m_lo = d & 16'h1FFC;
    if (p == PTR_CRITICAL && !crit_lock) m_cr = d & 16'h1FFC;
  endtask : wr_chk

  task automatic rd_chk(input logic [7:0] p);
    host.rd(p, rd_val);
    chk16(rd_val, exp_reg(p));
  endtask : rd_chk

  // One conversion; in the hysteresis band each trip holds its previous state.
  task automatic conv(input logic [11:0] t);
    int tv;
    int h;
    @(posedge ref_clk);
    conv_valid <= 1'b1;
    conv_temp  <= t;
    tv = sx({3'b000, t, 1'b0});
    h  = hyst_amt(hyst_sel);
    m_crit  = (tv >= sx(m_cr)) ? 1'b1 : (tv < sx(m_cr) - h) ? 1'b0 : m_crit;
    m_above = (tv > sx(m_up)) ? 1'b1 : (tv <= sx(m_up) - h) ? 1'b0 : m_above;
    m_below = (tv < sx(m_lo) - h) ? 1'b1 : (tv >= sx(m_lo)) ? 1'b0 : m_below;
    m_temp  = {3'b000, t, 1'b0};
    @(posedge ref_clk);
    conv_valid <= 1'b0;
    conv_temp  <= ~t;
    @(posedge ref_clk);
    #1;
    chk1(trip_critical, m_crit);
    chk1(trip_above, m_above);
    chk1(trip_below, m_below);
    chk1(in_window, !m_above && !m_below);
  endtask : conv

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk1(in_window, 1'b1);
    chk16(reg_rdata, 16'h0000);
    // Release on a rising edge so that the first strobe comes one full cycle later.
    @(posedge ref_clk);
    rst_n <= 1'b1;
    {m_up, m_lo, m_cr, m_temp} = '0;
    {m_crit, m_above, m_below} = 3'b000;
  endtask : do_reset

  task automatic test_done;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {error_cnt, tests_run} = '0;
    seed = 99052;
    {rst_n, conv_valid, alarm_lock, crit_lock, hyst_sel} = '0;
    conv_temp = 12'h000;
    do_reset;
    for (k = 2; k < 9; k++) rd_chk(k[7:0]);
    for (k = 2; k < 9; k++) wr_chk(k[7:0], 16'hFFFF);
    for (k = 2; k < 9; k++) rd_chk(k[7:0]);
    // Three in four temperatures are drawn close to a threshold so that equality and band edges occur.
    for (i = 0; i < 800; i++) begin
      k = $random(seed);
      hyst_sel   <= k[1:0];
      alarm_lock <= (k[4:2] == 3'd0);
      crit_lock  <= (k[7:5] == 3'd0);
      if (k[9:8] == 2'd0) wr_chk(8'h02 + {6'd0, k[11:10]}, 16'($random(seed)));
      case (k[13:12])
        2'd0:    base = m_up[12:1];
        2'd1:    base = m_lo[12:1];
        2'd2:    base = m_cr[12:1];
        default: base = k[31:20];
      endcase
      conv(base + 12'($signed(k[20:14])));
      if (k[22]) rd_chk(PTR_TEMP);
      if (k[23]) rd_chk(8'h02 + {6'd0, k[25:24]});
    end
    do_reset;
    for (k = 2; k < 8; k++) rd_chk(k[7:0]);
    test_done;
  end

  // Cut a hang short well beyond the expected run of about 5300 cycles.
  initial begin
    #100000;
    error_cnt++;
    test_done;
  end
endmodule : tb_ttr_regs
